//--- common/wrs_pkg.sv
package wrs_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_PERIOD_NS     = 10;
	localparam int unsigned TICK_TIME_NS        = 100000;
	localparam int unsigned TICK_CYCLES         = TICK_TIME_NS / CLOCK_PERIOD_NS;
	localparam int unsigned TICKS_PER_MS        = 1000000 / TICK_TIME_NS;

	// ----------------------------------------------------------------
	// Reset output timing
	// ----------------------------------------------------------------
	localparam int unsigned RESET_FILTER_TIME_NS = 10000;
	localparam int unsigned RESET_FILTER_CYCLES  = (RESET_FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned RESET_DELAY_TIME_MS  = 10;
	localparam int unsigned RESET_DELAY_TICKS    = RESET_DELAY_TIME_MS * TICKS_PER_MS;

	// ----------------------------------------------------------------
	// Watchdog timing
	// ----------------------------------------------------------------
	localparam int unsigned LONG_OPEN_WINDOW_TIME_MS = 200;
	localparam int unsigned LONG_OPEN_WINDOW_TICKS   = LONG_OPEN_WINDOW_TIME_MS * TICKS_PER_MS;
	localparam int unsigned CLOSED_WINDOW_PERCENT    = 60;
	localparam int unsigned OPEN_WINDOW_END_PERCENT  = 140;
	localparam int unsigned CNT_W                    = 14;

	// ----------------------------------------------------------------
	// Watchdog command byte fields
	// ----------------------------------------------------------------
	localparam int unsigned CMD_CHECKSUM_BIT = 7;
	localparam int unsigned CMD_WINDOW_BIT   = 5;
	localparam int unsigned CMD_RESERVED_BIT = 3;
	localparam int unsigned CMD_PERIOD_LSB   = 0;
	localparam logic        WINDOW_RESET     = 1'b0;
	localparam logic [2:0]  PERIOD_RESET     = 3'h1;

	// ----------------------------------------------------------------
	// Mode field codes and failure count limits
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_CODE_SLEEP  = 2'h1;
	localparam logic [1:0] MODE_CODE_STOP   = 2'h2;
	localparam logic [1:0] MODE_CODE_SOFT   = 2'h3;
	localparam logic [1:0] FAIL_CONFIG_2    = 2'h1;
	localparam logic [1:0] FAIL_MAX_CFG2    = 2'h1;
	localparam logic [1:0] FAIL_MAX_OTHER   = 2'h2;
	localparam logic [2:0] SYNC_RESET_VALUE = 3'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART,
	                          MODE_FAILSAFE} wrs_mode_e;

	typedef struct packed {
		logic       wdogWindowSelect;
		logic [2:0] wdogPeriodField;
	} wrs_cfg_s;

	localparam wrs_cfg_s CFG_RESET = '{wdogWindowSelect: WINDOW_RESET, wdogPeriodField: PERIOD_RESET};

	// Period in ms for settings 1..7; setting 0 falls back to the shortest
	function automatic int unsigned wrs_period_ms(input logic [2:0] setting);
		case (setting)
			3'h2:    return 20;
			3'h3:    return 50;
			3'h4:    return 100;
			3'h5:    return 200;
			3'h6:    return 500;
			3'h7:    return 1000;
			default: return 10;
		endcase
	endfunction : wrs_period_ms

	function automatic logic [CNT_W-1:0] wrs_ticks(input logic [2:0] setting, input int unsigned percent);
		int unsigned t;
		t = wrs_period_ms(setting) * TICKS_PER_MS * percent / 100;
		return t[CNT_W-1:0];
	endfunction : wrs_ticks

endpackage : wrs_pkg

//--- design/wrs_supervisor.sv
// What this block does
// - Reset event pulls reset low after filter time, holds it for event plus delay.
// - At power-up reset stays low until supply is good, then delay elapses.
// - A watchdog service failure also asserts the reset output.
// - Mode code 11 in Normal or Stop soft-resets to Init with default settings.
// - Soft reset command in any other mode is ignored.
// - Option bit chooses whether soft reset pulses the reset output with delay.
// - Window select and period only programmable in Normal, kept in Stop.
// - In Init the long open window starts after reset output release, or at once on soft reset when the option bit is clear.
// - After Init, Restart or Stop re-entry the watchdog opens a 200 ms window.
// - Watchdog off in Sleep and Restart; long window on Normal entry from Stop or Restart.
// - Watchdog is served by a config write acting at chip select rising edge.
// - A good-checksum config write outside the closed window restarts the timer with the new setting.
// - Period field selects 10, 20, 50, 100, 200, 500 or 1000 ms.
// - Watchdog reset enters Restart or Fail-Safe; release starts long window, Normal.
// - Development mode disables watchdog reset.
// - Each bad trigger or expiry counts up, saturating at 01 or 10.
// - Failure count clears on good trigger, on Sleep entry and on soft reset.
// - Time-out type: any trigger restarts period, expiry forces reset.
// - Window type: trigger in closed window or expiry forces reset.
// - Closed window is 60% of period; period is middle of open window.
// - Command bits must have even parity, reserved bit included as written.
// - Bad checksum command is dropped and sets the error flag.
`timescale 1ns/1ps
`default_nettype none

module wrs_supervisor #(
	parameter int unsigned TICK_CYCLES = wrs_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Asynchronous pins
	input  wire logic              vcc1Undervoltage,
	input  wire logic              chipSelectN,
	input  wire logic              developmentMode,
	// Frame decoder on this clock
	input  wire logic              wdogCmdValid,
	input  wire logic [7:0]        wdogCmdData,
	input  wire logic              modeWrite,
	input  wire logic [1:0]        modeField,
	// Configuration and events
	input  wire logic              softResetAssertOption,
	input  wire logic [1:0]        failConfig,
	input  wire logic              wakeEvent,
	input  wire logic              spiErrorClear,
	// Status
	output logic                   resetOutN,
	output wrs_pkg::wrs_mode_e     sbcMode,
	output wrs_pkg::wrs_cfg_s      wdogConfigReg,
	output logic [1:0]             wdogFailCount,
	output logic                   spiErrorFlag,
	output logic                   wdogRunning
);

	typedef enum logic [1:0] {RS_HOLD, RS_DELAY, RS_HIGH} wrs_rst_e;
	typedef enum logic [1:0] {WD_OFF, WD_LONG, WD_RUN} wrs_wd_e;

	localparam int unsigned FW = $clog2(wrs_pkg::RESET_FILTER_CYCLES + 1);
	localparam int unsigned DW = $clog2(wrs_pkg::RESET_DELAY_TICKS + 1);
	localparam int unsigned CW = wrs_pkg::CNT_W;

	logic       tick;
	logic [2:0] syncIn;
	logic       uvSync;
	logic       csSync;
	logic       devSync;

	// ----------------------------------------------------------------
	// Input synchronisers and time base
	// ----------------------------------------------------------------
	wrs_sync3 #(
		.WIDTH       (3),
		.RESET_VALUE (wrs_pkg::SYNC_RESET_VALUE)
	) u_sync (
		.clock   (clock),
		.rst_n   (rst_n),
		.asyncIn ({developmentMode, chipSelectN, vcc1Undervoltage}),
		.syncOut (syncIn)
	);

	assign uvSync  = syncIn[0];
	assign csSync  = syncIn[1];
	assign devSync = syncIn[2];

	wrs_tick_div #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.clock (clock),
		.rst_n (rst_n),
		.tick  (tick)
	);

	// ----------------------------------------------------------------
	// Reset output sequencer
	// ----------------------------------------------------------------
	wrs_rst_e      rstState;
	wrs_rst_e      next_rstState;
	logic [FW-1:0] filterCnt;
	logic [FW-1:0] next_filterCnt;
	logic [DW-1:0] delayCnt;
	logic [DW-1:0] next_delayCnt;
	logic          next_resetOutN;
	logic          resetOutPrev;
	logic          rstFallEvt;
	logic          next_rstFallEvt;
	logic          wdFailEvt;
	logic          softRstEvt;
	logic          holdLow;

	always_comb begin
		next_rstState   = rstState;
		next_filterCnt  = '0;
		next_delayCnt   = delayCnt;
		next_rstFallEvt = 1'b0;
		holdLow         = uvSync || sbcMode inside {wrs_pkg::MODE_FAILSAFE, wrs_pkg::MODE_SLEEP};
		case (rstState)
			RS_HOLD: begin
				if (!holdLow) begin
					next_rstState = RS_DELAY;
					next_delayCnt = '0;
				end
			end
			RS_DELAY: begin
				if (holdLow) begin
					next_rstState = RS_HOLD;
				end else if (tick) begin
					if (delayCnt == DW'(wrs_pkg::RESET_DELAY_TICKS - 1)) begin
						next_rstState = RS_HIGH;
					end else begin
						next_delayCnt = delayCnt + 1'b1;
					end
				end
			end
			RS_HIGH: begin
				if (uvSync) begin
					next_filterCnt = filterCnt + 1'b1;
				end
				if (wdFailEvt || softRstEvt || sbcMode == wrs_pkg::MODE_SLEEP) begin
					next_rstState = RS_DELAY;
					next_delayCnt = '0;
				end else if (uvSync && filterCnt == FW'(wrs_pkg::RESET_FILTER_CYCLES - 1)) begin
					next_rstState   = RS_HOLD;
					next_rstFallEvt = 1'b1;
				end
			end
			default: begin
				next_rstState = RS_HOLD;
			end
		endcase
		next_resetOutN = (next_rstState == RS_HIGH);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rstState     <= RS_HOLD;
			filterCnt    <= '0;
			delayCnt     <= '0;
			resetOutN    <= 1'b0;
			resetOutPrev <= 1'b0;
			rstFallEvt   <= 1'b0;
		end else begin
			rstState     <= next_rstState;
			filterCnt    <= next_filterCnt;
			delayCnt     <= next_delayCnt;
			resetOutN    <= next_resetOutN;
			resetOutPrev <= resetOutN;
			rstFallEvt   <= next_rstFallEvt;
		end
	end

	// ----------------------------------------------------------------
	// Mode control and watchdog
	// ----------------------------------------------------------------
	wrs_pkg::wrs_mode_e next_sbcMode;
	wrs_pkg::wrs_cfg_s  next_wdogConfigReg;
	wrs_wd_e            wdState;
	wrs_wd_e            next_wdState;
	logic [CW-1:0]      wdCnt;
	logic [CW-1:0]      next_wdCnt;
	logic [CW-1:0]      limit;
	logic [1:0]         next_wdogFailCount;
	logic [1:0]         failMax;
	logic               next_spiErrorFlag;
	logic               cmdPending;
	logic               next_cmdPending;
	logic [7:0]         cmdBuf;
	logic [7:0]         next_cmdBuf;
	logic               csPrev;
	logic               trigger;
	logic               inClosed;
	logic               expire;
	logic               wdFail;
	logic               releaseEvt;

	always_comb begin
		next_sbcMode       = sbcMode;
		next_wdogConfigReg = wdogConfigReg;
		next_wdState       = wdState;
		next_wdCnt         = wdCnt;
		next_wdogFailCount = wdogFailCount;
		next_spiErrorFlag  = spiErrorFlag && !spiErrorClear;
		next_cmdPending    = cmdPending;
		next_cmdBuf        = cmdBuf;
		wdFailEvt          = 1'b0;
		softRstEvt         = 1'b0;
		wdFail             = 1'b0;
		releaseEvt         = resetOutN && !resetOutPrev;
		failMax            = (failConfig == wrs_pkg::FAIL_CONFIG_2) ? wrs_pkg::FAIL_MAX_CFG2
		                                                            : wrs_pkg::FAIL_MAX_OTHER;
		if (wdogCmdValid) begin
			next_cmdPending = 1'b1;
			next_cmdBuf     = wdogCmdData;
		end
		trigger = csSync && !csPrev && cmdPending;
		if (csSync && !csPrev) begin
			next_cmdPending = wdogCmdValid;
		end
		if (wdState == WD_LONG) begin
			limit = CW'(wrs_pkg::LONG_OPEN_WINDOW_TICKS);
		end else if (wdogConfigReg.wdogWindowSelect) begin
			limit = wrs_pkg::wrs_ticks(wdogConfigReg.wdogPeriodField, wrs_pkg::OPEN_WINDOW_END_PERCENT);
		end else begin
			limit = wrs_pkg::wrs_ticks(wdogConfigReg.wdogPeriodField, 100);
		end
		inClosed = (wdState == WD_RUN) && wdogConfigReg.wdogWindowSelect
		        && (wdCnt < wrs_pkg::wrs_ticks(wdogConfigReg.wdogPeriodField,
		                                       wrs_pkg::CLOSED_WINDOW_PERCENT));
		expire = (wdState != WD_OFF) && tick && (wdCnt == limit - 1'b1);
		if (wdState != WD_OFF && tick) begin
			next_wdCnt = wdCnt + 1'b1;
		end

		// Mode requests
		if (modeWrite) begin
			case (modeField)
				wrs_pkg::MODE_CODE_NORMAL: begin
					if (sbcMode == wrs_pkg::MODE_STOP) begin
						next_sbcMode = wrs_pkg::MODE_NORMAL;
						next_wdState = WD_LONG;
						next_wdCnt   = '0;
					end else if (sbcMode == wrs_pkg::MODE_INIT) begin
						next_sbcMode = wrs_pkg::MODE_NORMAL;
					end
				end
				wrs_pkg::MODE_CODE_SLEEP: begin
					if (sbcMode == wrs_pkg::MODE_NORMAL) begin
						next_sbcMode       = wrs_pkg::MODE_SLEEP;
						next_wdState       = WD_OFF;
						next_wdogFailCount = '0;
					end
				end
				wrs_pkg::MODE_CODE_STOP: begin
					if (sbcMode == wrs_pkg::MODE_NORMAL) begin
						next_sbcMode = wrs_pkg::MODE_STOP;
					end
				end
				default: begin
					if (sbcMode == wrs_pkg::MODE_NORMAL || sbcMode == wrs_pkg::MODE_STOP) begin
						next_sbcMode       = wrs_pkg::MODE_INIT;
						next_wdogConfigReg = wrs_pkg::CFG_RESET;
						next_wdogFailCount = '0;
						next_spiErrorFlag  = 1'b0;
						next_cmdPending    = 1'b0;
						softRstEvt         = softResetAssertOption;
						next_wdState       = softResetAssertOption ? WD_OFF : WD_LONG;
						next_wdCnt         = '0;
					end
				end
			endcase
		end else if (trigger) begin
			if (^cmdBuf) begin
				next_spiErrorFlag = 1'b1;
			end else begin
				if (sbcMode == wrs_pkg::MODE_NORMAL) begin
					next_wdogConfigReg.wdogWindowSelect = cmdBuf[wrs_pkg::CMD_WINDOW_BIT];
					next_wdogConfigReg.wdogPeriodField  = cmdBuf[wrs_pkg::CMD_PERIOD_LSB +: 3];
				end
				if (wdState != WD_OFF) begin
					if (inClosed) begin
						wdFail = 1'b1;
					end else begin
						next_wdState       = WD_RUN;
						next_wdCnt         = '0;
						next_wdogFailCount = '0;
					end
				end
			end
		end else if (expire) begin
			wdFail = 1'b1;
		end

		if (wdFail) begin
			next_wdCnt = '0;
			if (wdogFailCount != failMax) begin
				next_wdogFailCount = wdogFailCount + 1'b1;
			end
			if (!devSync) begin
				wdFailEvt    = 1'b1;
				next_wdState = WD_OFF;
				next_sbcMode = (wdogFailCount == failMax) ? wrs_pkg::MODE_FAILSAFE
				                                          : wrs_pkg::MODE_RESTART;
			end
		end

		// Supply, wake and release events
		if (rstFallEvt && sbcMode != wrs_pkg::MODE_INIT) begin
			next_sbcMode = wrs_pkg::MODE_RESTART;
			next_wdState = WD_OFF;
		end else if (wakeEvent && (sbcMode == wrs_pkg::MODE_SLEEP || sbcMode == wrs_pkg::MODE_FAILSAFE)) begin
			next_sbcMode = wrs_pkg::MODE_RESTART;
		end else if (releaseEvt && (sbcMode == wrs_pkg::MODE_RESTART || sbcMode == wrs_pkg::MODE_INIT)) begin
			if (sbcMode == wrs_pkg::MODE_RESTART) begin
				next_sbcMode = wrs_pkg::MODE_NORMAL;
			end
			next_wdState = WD_LONG;
			next_wdCnt   = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sbcMode       <= wrs_pkg::MODE_INIT;
			wdogConfigReg <= wrs_pkg::CFG_RESET;
			wdState       <= WD_OFF;
			wdCnt         <= '0;
			wdogFailCount <= '0;
			spiErrorFlag  <= 1'b0;
			cmdPending    <= 1'b0;
			cmdBuf        <= '0;
			csPrev        <= 1'b1;
			wdogRunning   <= 1'b0;
		end else begin
			sbcMode       <= next_sbcMode;
			wdogConfigReg <= next_wdogConfigReg;
			wdState       <= next_wdState;
			wdCnt         <= next_wdCnt;
			wdogFailCount <= next_wdogFailCount;
			spiErrorFlag  <= next_spiErrorFlag;
			cmdPending    <= next_cmdPending;
			cmdBuf        <= next_cmdBuf;
			csPrev        <= csSync;
			wdogRunning   <= (next_wdState != WD_OFF);
		end
	end

endmodule : wrs_supervisor

`default_nettype wire

//--- design/wrs_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module wrs_sync3 #(
	parameter int unsigned   WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Asynchronous inputs and filtered result
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_syncOut;

	// ----------------------------------------------------------------
	// Per bit: accept a change once stages two and three agree
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_comb begin
			next_syncOut[i] = (stage2[i] == stage3[i]) ? stage3[i] : syncOut[i];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= RESET_VALUE;
			stage2  <= RESET_VALUE;
			stage3  <= RESET_VALUE;
			syncOut <= RESET_VALUE;
		end else begin
			stage1  <= asyncIn;
			stage2  <= stage1;
			stage3  <= stage2;
			syncOut <= next_syncOut;
		end
	end

endmodule : wrs_sync3

`default_nettype wire

//--- design/wrs_tick_div.sv
`timescale 1ns/1ps
`default_nettype none

module wrs_tick_div #(
	parameter int unsigned CYCLES = 10000
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// One-cycle enable at the slow rate
	output logic      tick
);

	logic [$clog2(CYCLES+1)-1:0] count;
	logic [$clog2(CYCLES+1)-1:0] next_count;
	logic                        next_tick;

	always_comb begin
		next_tick  = (count == $bits(count)'(CYCLES - 1));
		next_count = next_tick ? '0 : count + 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

endmodule : wrs_tick_div

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, o, e) begin check_count++; if ((o) !== (e)) begin err_total++; \
	$display("[FAIL] %0t sel %0d got %h want %h", $time, s, o, e); end end

module tb_top;
	// ------------
	// Signals
	// ------------
	typedef struct {int sel; logic [3:0] val;} wrs_note_s;
	localparam int RST = 0, MODE = 1, CFG = 2, FAIL = 3, ERR = 4, RUN = 5;
	localparam logic [3:0] INIT = {1'b0, wrs_pkg::MODE_INIT}, NORM = {1'b0, wrs_pkg::MODE_NORMAL};
	localparam logic [3:0] SLEEP = {1'b0, wrs_pkg::MODE_SLEEP}, RSTRT = {1'b0, wrs_pkg::MODE_RESTART};
	logic               clock, rst_n, vcc1Undervoltage, developmentMode, modeWrite, softResetAssertOption;
	logic               wakeEvent, spiErrorClear, serveReq, badSum, serveDone, chipSelectN, wdogCmdValid;
	logic               resetOutN, spiErrorFlag, wdogRunning;
	logic [1:0]         modeField, failConfig, wdogFailCount;
	logic [2:0]         per;
	logic [3:0]         holdCycles;
	logic [6:0]         serveBits;
	logic [7:0]         wdogCmdData;
	wrs_pkg::wrs_mode_e sbcMode;
	wrs_pkg::wrs_cfg_s  wdogConfigReg;
	wrs_note_s          notes[$];
	wrs_note_s          n;
	event               noteEv;
	int                 err_total = 0;
	int                 check_count = 0;
	int                 i;

	wrs_supervisor #(.TICK_CYCLES(4)) u_wrs_supervisor (
		.clock, .rst_n, .vcc1Undervoltage, .chipSelectN, .developmentMode, .wdogCmdValid, .wdogCmdData,
		.modeWrite, .modeField, .softResetAssertOption, .failConfig, .wakeEvent, .spiErrorClear,
		.resetOutN, .sbcMode, .wdogConfigReg, .wdogFailCount, .spiErrorFlag, .wdogRunning
	);
	wrs_mcu_model u_wrs_mcu_model (
		.clock, .serveReq, .serveBits, .badSum, .holdCycles, .serveDone, .chipSelectN, .wdogCmdValid, .wdogCmdData
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ------------
	// Expectation queue and monitor
	// ------------
	function automatic logic [3:0] observe(input int sel);
		case (sel)
			RST:     return {3'h0, resetOutN};
			MODE:    return {1'b0, sbcMode};
			CFG:     return wdogConfigReg;
			FAIL:    return {2'h0, wdogFailCount};
			RUN:     return {3'h0, wdogRunning};
			default: return {3'h0, spiErrorFlag};
		endcase
	endfunction : observe

	always @(noteEv) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			`CHK(n.sel, observe(n.sel), n.val)
		end
	end

	task automatic chk(input int sel, input logic [3:0] val);
		notes.push_back('{sel, val});
		-> noteEv;
	endtask : chk

	task automatic idle(input int cyc);
		repeat (cyc) @(posedge clock);
		#1;
	endtask : idle

	task automatic await_out(input int sel, input logic [3:0] val, input int lim);
		for (int k = 0; k < lim && observe(sel) !== val; k++) idle(1);
		chk(sel, val);
		idle(2);
	endtask : await_out

	task automatic set_mode(input logic [1:0] f);
		@(negedge clock) modeWrite = 1'b1;
		modeField = f;
		@(negedge clock) modeWrite = 1'b0;
		idle(1);
	endtask : set_mode

	task automatic serve(input logic [6:0] bits, input logic bad);
		@(negedge clock) serveBits = bits;
		badSum = bad;
		holdCycles = 4'($urandom_range(0, 7));
		serveReq = 1'b1;
		wait (serveDone === 1'b1);
		@(negedge clock) serveReq = 1'b0;
		idle(2);
	endtask : serve

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// ------------
	// Scenarios
	// ------------
	initial begin
		void'($urandom(22));
		{rst_n, vcc1Undervoltage, developmentMode, modeWrite, softResetAssertOption, wakeEvent} = 6'h0;
		{spiErrorClear, serveReq, badSum, modeField, serveBits, holdCycles} = 16'h0;
		failConfig = 2'($urandom_range(0, 3));
		repeat (4) @(posedge clock);
		@(negedge clock) rst_n = 1'b1;
		idle(50);
		chk(RST, 4'h0);
		chk(MODE, INIT);
		await_out(RST, 4'h1, 1000);
		set_mode(wrs_pkg::MODE_CODE_NORMAL);
		chk(MODE, NORM);
		serve(7'h01, 1'b1);
		chk(ERR, 4'h1);
		chk(CFG, 4'h1);
		@(negedge clock) spiErrorClear = 1'b1;
		@(negedge clock) spiErrorClear = 1'b0;
		idle(2);
		chk(ERR, 4'h0);
		repeat (3) begin
			per = 3'($urandom_range(1, 7));
			serve({3'h0, 1'($urandom_range(0, 1)), per}, 1'b0);
			chk(CFG, {1'b0, per});
			chk(ERR, 4'h0);
		end
		serve(7'h01, 1'b0);
		repeat (2) begin
			idle(300);
			serve(7'h01, 1'b0);
		end
		chk(RST, 4'h1);
		await_out(RST, 4'h0, 600);
		chk(FAIL, 4'h1);
		chk(MODE, RSTRT);
		await_out(RST, 4'h1, 600);
		chk(MODE, NORM);
		idle(1000);
		chk(RST, 4'h1);
		serve(7'h21, 1'b0);
		chk(CFG, 4'h9);
		chk(FAIL, 4'h0);
		idle(100);
		serve(7'h21, 1'b0);
		await_out(RST, 4'h0, 50);
		chk(FAIL, 4'h1);
		await_out(RST, 4'h1, 600);
		serve(7'h21, 1'b0);
		idle(380);
		serve(7'h21, 1'b0);
		chk(FAIL, 4'h0);
		idle(100);
		chk(RST, 4'h1);
		@(negedge clock) developmentMode = 1'b1;
		idle(10);
		serve(7'h01, 1'b0);
		idle(1000);
		chk(RST, 4'h1);
		serve(7'h01, 1'b0);
		@(negedge clock) developmentMode = 1'b0;
		set_mode(wrs_pkg::MODE_CODE_SLEEP);
		chk(MODE, SLEEP);
		chk(RUN, 4'h0);
		set_mode(wrs_pkg::MODE_CODE_SOFT);
		chk(MODE, SLEEP);
		chk(FAIL, 4'h0);
		@(negedge clock) wakeEvent = 1'b1;
		@(negedge clock) wakeEvent = 1'b0;
		await_out(MODE, NORM, 1000);
		chk(RUN, 4'h1);
		for (i = 0; i < 2; i++) begin
			@(negedge clock) softResetAssertOption = i[0];
			serve(7'h03, 1'b0);
			chk(CFG, 4'h3);
			if (i == 0) begin
				set_mode(wrs_pkg::MODE_CODE_STOP);
				serve(7'h21, 1'b0);
				chk(CFG, 4'h3);
			end
			set_mode(wrs_pkg::MODE_CODE_SOFT);
			chk(MODE, INIT);
			chk(CFG, 4'h1);
			chk(RST, {3'h0, !i[0]});
			await_out(RST, 4'h1, 600);
			set_mode(wrs_pkg::MODE_CODE_NORMAL);
		end
		@(negedge clock) vcc1Undervoltage = 1'b1;
		idle(900);
		chk(RST, 4'h1);
		idle(200);
		chk(RST, 4'h0);
		@(negedge clock) vcc1Undervoltage = 1'b0;
		idle(300);
		chk(RST, 4'h0);
		await_out(RST, 4'h1, 400);
		give_verdict();
	end

	initial begin
		repeat (30000) @(posedge clock);
		err_total++;
		give_verdict();
	end
endmodule : tb_top

bind wrs_supervisor wrs_supervisor_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_wrs_supervisor_asserts (
	.clock, .rst_n, .vcc1Undervoltage, .chipSelectN, .developmentMode, .wdogCmdValid, .wdogCmdData, .modeWrite,
	.modeField, .softResetAssertOption, .resetOutN, .sbcMode, .wdogConfigReg, .wdogFailCount, .spiErrorFlag,
	.wdogRunning
);

`default_nettype wire

//--- dv/wrs_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

module wrs_mcu_model (
	// Clock
	input  wire logic       clock,
	// Service request from the bench
	input  wire logic       serveReq,
	input  wire logic [6:0] serveBits,
	input  wire logic       badSum,
	input  wire logic [3:0] holdCycles,
	output logic            serveDone,
	// Frame toward the supervisor
	output logic            chipSelectN,
	output logic            wdogCmdValid,
	output logic [7:0]      wdogCmdData
);
	// ------------
	// One watchdog write frame per request
	// ------------
	initial begin
		chipSelectN  = 1'b1;
		wdogCmdValid = 1'b0;
		wdogCmdData  = 8'h5a;
		serveDone    = 1'b0;
		forever begin
			@(negedge clock);
			if (serveReq) begin
				chipSelectN = 1'b0;
				@(negedge clock);
				wdogCmdValid = 1'b1;
				wdogCmdData  = {(^serveBits) ^ badSum, serveBits};
				@(negedge clock);
				wdogCmdValid = 1'b0;
				wdogCmdData  = ~wdogCmdData;
				repeat (holdCycles) @(negedge clock);
				chipSelectN = 1'b1;
				repeat (8) @(negedge clock);
				serveDone = 1'b1;
				do @(posedge clock); while (serveReq);
				@(negedge clock) serveDone = 1'b0;
			end
		end
	end
endmodule : wrs_mcu_model

`default_nettype wire

//--- dv/wrs_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module wrs_supervisor_asserts #(
	parameter int unsigned TICK_CYCLES = 4
) (
	// Clock and reset
	input wire logic                clock,
	input wire logic                rst_n,
	// Inputs
	input wire logic                vcc1Undervoltage,
	input wire logic                chipSelectN,
	input wire logic                developmentMode,
	input wire logic                wdogCmdValid,
	input wire logic [7:0]          wdogCmdData,
	input wire logic                modeWrite,
	input wire logic [1:0]          modeField,
	input wire logic                softResetAssertOption,
	// Outputs
	input wire logic                resetOutN,
	input wire wrs_pkg::wrs_mode_e  sbcMode,
	input wire wrs_pkg::wrs_cfg_s   wdogConfigReg,
	input wire logic [1:0]          wdogFailCount,
	input wire logic                spiErrorFlag,
	input wire logic                wdogRunning
);
	// ------------
	// Helper counters
	// ------------
	localparam int unsigned FILT = wrs_pkg::RESET_FILTER_CYCLES + 6;
	localparam int unsigned DLY  = (wrs_pkg::RESET_DELAY_TICKS - 1) * TICK_CYCLES;
	logic [31:0] uvCnt, lowCnt, next_uvCnt, next_lowCnt;

	always_comb begin
		next_uvCnt  = vcc1Undervoltage ? uvCnt + 32'h1 : 32'h0;
		next_lowCnt = resetOutN ? 32'h0 : lowCnt + 32'h1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			uvCnt  <= 32'h0;
			lowCnt <= 32'h0;
		end else begin
			uvCnt  <= next_uvCnt;
			lowCnt <= next_lowCnt;
		end
	end

	// ------------
	// Properties
	// ------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_uv_filter_low: assert property (uvCnt > FILT |-> !resetOutN)
		else $error("reset high under undervoltage");
	a_release_delay: assert property ($rose(resetOutN) |-> lowCnt >= DLY)
		else $error("early reset release");
	a_normal_after_release: assert property ($rose(resetOutN) && sbcMode == wrs_pkg::MODE_RESTART
		|-> ##[0:2] sbcMode == wrs_pkg::MODE_NORMAL) else $error("no normal after release");
	a_sleep_wdog_off: assert property (sbcMode == wrs_pkg::MODE_SLEEP && $past(sbcMode) == wrs_pkg::MODE_SLEEP
		|-> !wdogRunning && wdogFailCount == 2'h0) else $error("watchdog on in sleep");
	a_fail_count_step: assert property ($changed(wdogFailCount)
		|-> wdogFailCount == 2'h0 || wdogFailCount == 2'($past(wdogFailCount) + 2'h1)) else $error("bad count step");
	a_config_normal_only: assert property ($changed(wdogConfigReg)
		|-> $past(sbcMode) == wrs_pkg::MODE_NORMAL || wdogConfigReg == wrs_pkg::CFG_RESET) else $error("config outside normal");
	a_config_after_cs: assert property ($changed(wdogConfigReg) && wdogConfigReg != wrs_pkg::CFG_RESET
		|-> $past(chipSelectN, 4)) else $error("config before cs rise");
	a_bad_sum_flag: assert property (wdogCmdValid && ^wdogCmdData |-> ##[1:16] spiErrorFlag)
		else $error("no error flag");
	a_dev_no_reset: assert property (developmentMode [*8] ##0 resetOutN |=> resetOutN)
		else $error("reset in dev mode");
	a_soft_reset_init: assert property (modeWrite && modeField == wrs_pkg::MODE_CODE_SOFT
		&& sbcMode inside {wrs_pkg::MODE_NORMAL, wrs_pkg::MODE_STOP} |=> sbcMode == wrs_pkg::MODE_INIT
		&& wdogConfigReg == wrs_pkg::CFG_RESET && resetOutN == !$past(softResetAssertOption)) else $error("soft reset");
	a_soft_reset_ignored: assert property (modeWrite && modeField == wrs_pkg::MODE_CODE_SOFT
		&& !(sbcMode inside {wrs_pkg::MODE_NORMAL, wrs_pkg::MODE_STOP}) |=> $stable(sbcMode)) else $error("soft reset taken");

	c_restart: cover property (sbcMode == wrs_pkg::MODE_RESTART);
	c_soft: cover property (modeWrite && modeField == wrs_pkg::MODE_CODE_SOFT);
	c_bad_sum: cover property ($rose(spiErrorFlag));
endmodule : wrs_supervisor_asserts

`default_nettype wire
